// ### design/pulse_pattern_output_groups.sv
// Purpose: Pattern output groups moving staged bits to output bits on timer compare events.
// Assumes: Compare inputs are single-cycle pulses synchronous to core_clk.
// Notes:   APB slave with zero wait states; unmapped addresses read zero and flag pslverr.
`timescale 1ns/1ps
`default_nettype none
module pulse_pattern_output_groups
  import pulse_pattern_pkg::*;
(
  // Clock, reset and enable
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          clk_en,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Companion timer compare events
  input  wire timer_events_s timer_ev,
  // Pattern pins
  output logic      [15:0]   pattern_out,
  output logic      [15:0]   pattern_oe
);

  ppg_state_s st_r;
  ppg_state_s st_nxt;

  function automatic logic [15:0] pin_value(input logic [15:0] data, input logic [7:0] mode);
    logic [15:0] v;
    v = data;
    for (int g = 0; g < GROUPS; g++)
    begin
      if (!mode[INV_LSB + g])
      begin
        v[g*GROUP_BITS +: GROUP_BITS] = ~data[g*GROUP_BITS +: GROUP_BITS];
      end
    end
    return v;
  endfunction

  logic wr_acc;
  logic rd_acc;
  logic [31:0] rd_val;
  logic rd_hit;

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;

  always_comb
  begin
    rd_hit = 1'b1;
    unique case (paddr)
      OFS_MODE:      rd_val = {24'h000000, st_r.mode};
      OFS_TRIG_SEL:  rd_val = {24'h000000, st_r.trig_sel};
      OFS_NEXT_DATA: rd_val = {16'h0000, st_r.next_data};
      OFS_OUT_DATA:  rd_val = {16'h0000, st_r.out_data};
      OFS_NEXT_EN:   rd_val = {16'h0000, st_r.next_en};
      OFS_DIRECTION: rd_val = {16'h0000, st_r.direction};
      OFS_PIN_STATE: rd_val = {16'h0000, st_r.pin_level};
      default:
      begin
        rd_val = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Software writes land first; a match A in the same cycle then overrides the written output bits, a match B in non-overlap mode ANDs them with the staged bits.
  always_comb
  begin
    logic [SEL_BITS-1:0] sel;
    logic                ev_a;
    logic                ev_b;
    logic [3:0]          nd;
    st_nxt = st_r;
    sel = '0;
    ev_a = 1'b0;
    ev_b = 1'b0;
    nd = '0;
    st_nxt.pslverr = 1'b0;
    if (rd_acc)
    begin
      st_nxt.prdata  = rd_val;
    end
    if (psel && !penable)
    begin
      st_nxt.pslverr = !rd_hit;
    end
    if (wr_acc)
    begin
      unique case (paddr)
        OFS_MODE:      st_nxt.mode = pwdata[7:0];
        OFS_TRIG_SEL:  st_nxt.trig_sel = pwdata[7:0];
        OFS_NEXT_DATA: st_nxt.next_data = pwdata[15:0];
        OFS_OUT_DATA:  st_nxt.out_data = pwdata[15:0];
        OFS_NEXT_EN:   st_nxt.next_en = pwdata[15:0];
        OFS_DIRECTION: st_nxt.direction = pwdata[15:0];
        default:       st_nxt.prdata = st_r.prdata;
      endcase
    end
    for (int g = 0; g < GROUPS; g++)
    begin
      sel  = st_r.trig_sel[g*SEL_BITS +: SEL_BITS];
      ev_a = timer_ev.match_a[sel];
      ev_b = timer_ev.match_b[sel] && st_r.mode[NOV_LSB + g];
      nd   = st_r.next_data[g*GROUP_BITS +: GROUP_BITS];
      if (ev_a)
      begin
        st_nxt.out_data[g*GROUP_BITS +: GROUP_BITS] = nd;
      end
      else if (ev_b)
      begin
        st_nxt.out_data[g*GROUP_BITS +: GROUP_BITS] = st_nxt.out_data[g*GROUP_BITS +: GROUP_BITS] & nd;
      end
    end
    st_nxt.pin_level = pin_value(st_nxt.out_data, st_nxt.mode);
    st_nxt.pin_oe    = st_nxt.direction & st_nxt.next_en;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st_r           <= '0;
      st_r.mode      <= MODE_RESET;
      st_r.trig_sel  <= TRIG_SEL_RESET;
      st_r.out_data  <= DATA_RESET;
      st_r.pin_level <= DATA_RESET;
    end
    else if (clk_en)
    begin
      st_r <= st_nxt;
    end
  end

  // Every register answers in its access phase, so the slave never stalls the bus.
  assign prdata      = st_r.prdata;
  assign pslverr     = st_r.pslverr;
  assign pready      = 1'b1;
  assign pattern_out = st_r.pin_level;
  assign pattern_oe  = st_r.pin_oe;

  // Group 0 stands in for all four, group 3 for the direct pin level; every group runs the same loop body.
  logic [SEL_BITS-1:0] g0_sel;
  assign g0_sel = st_r.trig_sel[SEL_BITS-1:0];

  sequence s_g0_match_a;
    clk_en && timer_ev.match_a[g0_sel];
  endsequence

  sequence s_g0_match_b;
    clk_en && !wr_acc && st_r.mode[NOV_LSB] && timer_ev.match_b[g0_sel] && !timer_ev.match_a[g0_sel];
  endsequence

  a_copy_on_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_g0_match_a |=> st_r.out_data[3:0] == $past(st_r.next_data[3:0]))
    else $error("Group 0 did not copy staged data on match A.");

  a_nov_b_and: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_g0_match_b
    |=> st_r.out_data[3:0] == ($past(st_r.out_data[3:0]) & $past(st_r.next_data[3:0])))
    else $error("Group 0 match B transfer was wrong.");

  a_nov_no_rise: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_g0_match_b |=> (st_r.out_data[3:0] & ~$past(st_r.out_data[3:0])) == 4'h0)
    else $error("Group 0 match B raised an output bit.");

  a_freeze_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    !clk_en |=> $stable(st_r))
    else $error("State moved while the clock enable was low.");

  a_err_unmapped: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && psel && !penable && !rd_hit |=> pslverr)
    else $error("Unmapped access did not flag an error.");

  a_read_data: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && rd_acc && paddr == OFS_OUT_DATA |=> prdata == {16'h0000, $past(st_r.out_data)})
    else $error("Read of output data returned a wrong value.");

  a_normal_b_ign: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && !wr_acc && !st_r.mode[NOV_LSB] && !timer_ev.match_a[g0_sel]
    |=> st_r.out_data[3:0] == $past(st_r.out_data[3:0]))
    else $error("Group 0 output changed without a trigger.");

  a_pin_invert: assert property (@(posedge core_clk) disable iff (!rst_n)
    !st_r.mode[INV_LSB] |-> pattern_out[3:0] == ~st_r.out_data[3:0])
    else $error("Inverted group 0 pin level wrong.");

  a_pin_direct: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_r.mode[INV_LSB + 3] |-> pattern_out[15:12] == st_r.out_data[15:12])
    else $error("Direct group 3 pin level wrong.");

  a_enable_and: assert property (@(posedge core_clk) disable iff (!rst_n)
    pattern_oe == (st_r.direction & st_r.next_en))
    else $error("Output enable not direction and enable.");

  a_load_seen: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && wr_acc && paddr == OFS_OUT_DATA && timer_ev.match_a == '0 && timer_ev.match_b == '0
    |=> st_r.out_data == $past(pwdata[15:0]))
    else $error("Loaded output data not presented.");

  a_reset_vals: assert property (@(posedge core_clk)
    $rose(rst_n) |-> st_r.trig_sel == TRIG_SEL_RESET && st_r.mode == MODE_RESET)
    else $error("Reset values of select or mode wrong.");

endmodule // pulse_pattern_output_groups
`default_nettype wire

// ### design/pulse_pattern_pkg.sv
// Purpose: Constants, register map and carrier types for the pulse pattern output groups.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Offsets are byte addresses.
package pulse_pattern_pkg;

  localparam int unsigned GROUPS      = 4;
  localparam int unsigned GROUP_BITS  = 4;
  localparam int unsigned OUT_BITS    = 16;
  localparam int unsigned CHANNELS    = 4;
  localparam int unsigned SEL_BITS    = 2;

  localparam logic [7:0] OFS_MODE      = 8'h00;
  localparam logic [7:0] OFS_TRIG_SEL  = 8'h04;
  localparam logic [7:0] OFS_NEXT_DATA = 8'h08;
  localparam logic [7:0] OFS_OUT_DATA  = 8'h0C;
  localparam logic [7:0] OFS_NEXT_EN   = 8'h10;
  localparam logic [7:0] OFS_DIRECTION = 8'h14;
  localparam logic [7:0] OFS_PIN_STATE = 8'h18;

  localparam int unsigned INV_LSB = 4;
  localparam int unsigned NOV_LSB = 0;

  localparam logic [7:0]  MODE_RESET     = 8'hF0;
  localparam logic [7:0]  TRIG_SEL_RESET = 8'hFF;
  localparam logic [15:0] DATA_RESET     = 16'h0000;

  typedef struct packed {
    logic [7:0]  mode;
    logic [7:0]  trig_sel;
    logic [15:0] next_data;
    logic [15:0] out_data;
    logic [15:0] next_en;
    logic [15:0] direction;
    logic [15:0] pin_level;
    logic [15:0] pin_oe;
    logic [31:0] prdata;
    logic        pslverr;
  } ppg_state_s;

  typedef struct packed {
    logic [CHANNELS-1:0] match_a;
    logic [CHANNELS-1:0] match_b;
  } timer_events_s;

endpackage

// ### tb/phase_load_model.sv
// Purpose: Phase driver loads hanging on the pattern pins.
// Assumes: Each load input has a pull-down.
// Notes:   A pin that is not driven reads as the pull-down level.
`timescale 1ns/1ps
`default_nettype none
module phase_load_model (
  // Pins from the pattern block
  input  wire logic [15:0] pattern_out,
  input  wire logic [15:0] pattern_oe,
  // Level seen by each phase driver
  output logic      [15:0] load_level
);
  // A released pin falls to the pull-down, so a stale level never passes for drive.
  assign load_level = pattern_out & pattern_oe;
endmodule // phase_load_model
`default_nettype wire

// ### tb/test_pulse_pattern_output_groups.sv
// Purpose: Self-checking bench for the pulse pattern output groups.
// Assumes: Zero-wait APB slave; compare pulses act one edge after launch.
// Notes:   Pins are seen through the load model.
`timescale 1ns/1ps
`default_nettype none
module test_pulse_pattern_output_groups;
  import pulse_pattern_pkg::*;
  logic          core_clk = 1'b0;
  logic          rst_n = 1'b0;
  logic          clk_en = 1'b1;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [7:0]    paddr = 8'h00;
  logic [31:0]   pwdata = 32'h0;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  timer_events_s timer_ev = '0;
  logic [15:0]   pattern_out;
  logic [15:0]   pattern_oe;
  logic [15:0]   load_level;
  logic [31:0]   rd;
  logic          er;
  logic [15:0]   cur, nd, dr, en;
  logic [7:0]    md, ts, ev;
  int            fail_count = 0;
  int            compares = 0;
  int            seed = 32'hf94a;
  always #12.5 core_clk = ~core_clk;
  pulse_pattern_output_groups i_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_ev(timer_ev), .pattern_out(pattern_out), .pattern_oe(pattern_oe));
  phase_load_model i_load (.pattern_out(pattern_out), .pattern_oe(pattern_oe), .load_level(load_level));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic pulse(input logic [7:0] e);
    timer_ev <= timer_events_s'(e);
    @(posedge core_clk);
    timer_ev <= '0;
    @(posedge core_clk);
  endtask
  function automatic logic [15:0] pins(input logic [7:0] m, input logic [15:0] o);
    for (int g = 0; g < 4; g++)
      pins[4*g+:4] = m[4+g] ? o[4*g+:4] : ~o[4*g+:4];
  endfunction
  // Match A wins over match B; match B only clears bits whose staged value is zero.
  function automatic logic [15:0] step(input logic [7:0] m, t, input logic [15:0] o, n, input logic [7:0] e);
    step = o;
    for (int g = 0; g < 4; g++)
      if (e[4+t[2*g+:2]])
        step[4*g+:4] = n[4*g+:4];
      else if (m[g] && e[t[2*g+:2]])
        step[4*g+:4] = o[4*g+:4] & n[4*g+:4];
  endfunction
  task automatic wrap_up;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, OFS_MODE, 32'h0);
    chk(rd, 32'hF0);
    apb(1'b0, OFS_TRIG_SEL, 32'h0);
    chk(rd, 32'hFF);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("test reset_values done");
    // Non-overlap on channel 0: match B clears first, match A then sets the rest.
    apb(1'b1, OFS_MODE, 32'hFF);
    apb(1'b1, OFS_TRIG_SEL, 32'h00);
    apb(1'b1, OFS_OUT_DATA, 32'hF0F0);
    apb(1'b1, OFS_NEXT_DATA, 32'h3C3C);
    pulse(8'h01);
    apb(1'b0, OFS_PIN_STATE, 32'h0);
    chk(rd, 32'h3030);
    pulse(8'h10);
    apb(1'b0, OFS_PIN_STATE, 32'h0);
    chk(rd, 32'h3C3C);
    // A low clock enable must swallow a compare pulse.
    apb(1'b1, OFS_NEXT_DATA, 32'h0);
    clk_en <= 1'b0;
    timer_ev <= timer_events_s'(8'hF0);
    @(posedge core_clk);
    clk_en <= 1'b1;
    timer_ev <= '0;
    @(posedge core_clk);
    apb(1'b0, OFS_OUT_DATA, 32'h0);
    chk(rd, 32'h3C3C);
    // Normal mode must ignore match B.
    apb(1'b1, OFS_MODE, 32'hF0);
    pulse(8'h01);
    apb(1'b0, OFS_OUT_DATA, 32'h0);
    chk(rd, 32'h3C3C);
    $display("test corner_cases done");
    repeat (32)
    begin
      cur = $random(seed);
      nd  = $random(seed);
      dr  = $random(seed);
      en  = $random(seed);
      md  = $random(seed);
      ts  = $random(seed);
      ev  = $random(seed);
      apb(1'b1, OFS_DIRECTION, {16'h0, dr});
      apb(1'b1, OFS_NEXT_EN, {16'h0, en});
      apb(1'b1, OFS_OUT_DATA, {16'h0, cur});
      apb(1'b1, OFS_MODE, {24'h0, md});
      apb(1'b1, OFS_TRIG_SEL, {24'h0, ts});
      apb(1'b1, OFS_NEXT_DATA, {16'h0, nd});
      chk({16'h0, pattern_oe}, {16'h0, dr & en});
      chk({16'h0, load_level}, {16'h0, pins(md, cur) & dr & en});
      pulse(ev);
      cur = step(md, ts, cur, nd, ev);
      chk({16'h0, load_level}, {16'h0, pins(md, cur) & dr & en});
      apb(1'b0, OFS_OUT_DATA, 32'h0);
      chk(rd, {16'h0, cur});
      apb(1'b0, OFS_PIN_STATE, 32'h0);
      chk(rd, {16'h0, pins(md, cur)});
    end
    $display("test random_transfers done");
    wrap_up();
  end
  initial
  begin
    #1000000;
    fail_count++;
    wrap_up();
  end
endmodule // test_pulse_pattern_output_groups
`default_nettype wire
